// [core/spi_flash_link_if.sv]
// four-lane flash link between the host end and the device end
// assumes nobody else drives the lanes; an undriven lane reads high (pull-up)
`timescale 1ns/1ps
interface spi_flash_link_if;
	logic       sclk;
	logic       cs_n;
	logic [3:0] host_o;
	logic [3:0] host_oe;
	logic [3:0] dev_o;
	logic [3:0] dev_oe;
	logic [3:0] io;

	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign io[i] = host_oe[i] ? host_o[i] : (dev_oe[i] ? dev_o[i] : 1'b1);
	end

	modport host_mp (output sclk, output cs_n, output host_o, output host_oe, input io);
	modport dev_mp  (input sclk, input cs_n, input io, output dev_o, output dev_oe);
endinterface : spi_flash_link_if

// [core/spi_flash_pkg.sv]
// opcodes, phase codes, lane and dummy-count helpers for both link ends
// assumes mode-0 style link: sample on rising sclk, drive on falling sclk
package spi_flash_pkg;

	localparam int         ADDR_BITS     = 24;
	localparam logic [7:0] OP_READ       = 8'h03;
	localparam logic [7:0] OP_FAST       = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT   = 8'h3b;
	localparam logic [7:0] OP_QUAD_OUT   = 8'h6b;
	localparam logic [7:0] OP_DUAL_IO    = 8'hbb;
	localparam logic [7:0] OP_QUAD_IO    = 8'heb;
	localparam logic [7:0] OP_ENTER_QPI  = 8'h38;
	localparam logic [7:0] OP_EXIT       = 8'hff;
	localparam logic [7:0] OP_SET_PARAM  = 8'hc0;
	localparam logic [1:0] CONT_MATCH    = 2'h2;
	localparam int         PARAM_LSB     = 4;
	localparam logic [1:0] DCFG_RST      = 2'h0;
	localparam logic [4:0] ADDR_LEN      = 5'h18;
	localparam logic [4:0] BYTE_LEN      = 5'h08;
	localparam logic [4:0] SPI_FAST_DUM  = 5'h08;
	localparam logic [4:0] SPI_QIO_DUM   = 5'h04;
	localparam logic [4:0] QPI_MODE_CLKS = 5'h02;
	localparam logic [4:0] DUM_CODE0     = 5'h04;
	localparam logic [4:0] DUM_CODE1     = 5'h04;
	localparam logic [4:0] DUM_CODE2     = 5'h06;
	localparam logic [4:0] DUM_CODE3     = 5'h08;

	typedef enum logic [5:0] {
		PH_IDLE  = 6'h01,
		PH_CMD   = 6'h02,
		PH_ADDR  = 6'h04,
		PH_MODE  = 6'h08,
		PH_DUMMY = 6'h10,
		PH_DATA  = 6'h20
	} phase_e;

	function automatic logic [2:0] cmd_lanes(input logic four_wire_command_mode);
		return four_wire_command_mode ? 3'h4 : 3'h1;
	endfunction : cmd_lanes

	function automatic logic [2:0] addr_lanes(input logic [7:0] op, input logic four_wire_command_mode);
		if (four_wire_command_mode) return 3'h4;
		if (op == OP_DUAL_IO) return 3'h2;
		if (op == OP_QUAD_IO) return 3'h4;
		return 3'h1;
	endfunction : addr_lanes

	function automatic logic [2:0] data_lanes(input logic [7:0] op, input logic four_wire_command_mode);
		if (four_wire_command_mode) return 3'h4;
		if (op == OP_DUAL_OUT || op == OP_DUAL_IO) return 3'h2;
		if (op == OP_QUAD_OUT || op == OP_QUAD_IO) return 3'h4;
		return 3'h1;
	endfunction : data_lanes

	function automatic logic [4:0] clocks_for(input logic [4:0] bits, input logic [2:0] lanes);
		if (lanes == 3'h4) return bits >> 2;
		if (lanes == 3'h2) return bits >> 1;
		return bits;
	endfunction : clocks_for

	function automatic logic has_mode(input logic [7:0] op);
		return op == OP_DUAL_IO || op == OP_QUAD_IO;
	endfunction : has_mode

	function automatic logic [4:0] dummy_clocks(input logic [7:0] op, input logic four_wire_command_mode,
	                                            input logic [1:0] dcfg);
		logic [4:0] d;
		case (dcfg)
			2'h0:    d = DUM_CODE0;
			2'h1:    d = DUM_CODE1;
			2'h2:    d = DUM_CODE2;
			default: d = DUM_CODE3;
		endcase
		if (four_wire_command_mode) begin
			if (op == OP_FAST) return d;
			if (op == OP_QUAD_IO) return 5'(d - QPI_MODE_CLKS);
			return 5'h00;
		end
		if (op == OP_FAST || op == OP_DUAL_OUT || op == OP_QUAD_OUT) return SPI_FAST_DUM;
		if (op == OP_QUAD_IO) return SPI_QIO_DUM;
		return 5'h00;
	endfunction : dummy_clocks

	function automatic logic [3:0] lane_mask(input logic [2:0] lanes);
		if (lanes == 3'h4) return 4'hf;
		if (lanes == 3'h2) return 4'h3;
		return 4'h1;
	endfunction : lane_mask

endpackage : spi_flash_pkg

// [core/spi_flash_read_device.sv]
// flash device end: read command front end, runs on the link clock
// assumes i_rd_data is a combinational lookup of o_rd_addr on the link side,
// and i_quad_enable / i_busy are steady core-clock levels
`timescale 1ns/1ps
module spi_flash_read_device (
	spi_flash_link_if.dev_mp                  link,
	input  wire logic                         i_core_clk,
	input  wire logic                         i_rst_n,
	input  wire logic                         i_clk_en,
	input  wire logic                         i_quad_enable,
	input  wire logic                         i_busy,
	input  wire logic [7:0]                   i_rd_data,
	output logic      [spi_flash_pkg::ADDR_BITS-1:0] o_rd_addr,
	output logic                              o_four_wire_mode,
	output logic                              o_continuous_armed
);
	import spi_flash_pkg::*;

	// persistent link-side state; survives chip select
	typedef struct packed {
		logic       qe_s1;
		logic       qe_s2;
		logic       busy_s1;
		logic       busy_s2;
		logic       en_s1;
		logic       en_s2;
		logic       four_wire_command_mode;
		logic       cont;
		logic       cont_quad;
		logic [1:0] dcfg;
	} persist_s;

	// per-frame receive state; cleared by chip select high
	typedef struct packed {
		logic        fresh;
		phase_e      phase;
		logic [7:0]  op;
		logic [4:0]  cnt;
		logic [31:0] sh;
		logic [23:0] addr;
	} frame_s;

	// falling-edge output state
	typedef struct packed {
		logic [7:0]  sh;
		logic [3:0]  bits;
		logic [3:0]  oe;
		logic [3:0]  left;
		logic [23:0] next_addr;
		logic        started;
	} drive_s;

	// core-clock view of the mode flags
	typedef struct packed {
		logic qpi_s1;
		logic qpi_s2;
		logic cont_s1;
		logic cont_s2;
	} core_s;

	localparam persist_s P_RST = '{qe_s1: 1'b0, qe_s2: 1'b0, busy_s1: 1'b0, busy_s2: 1'b0,
		en_s1: 1'b1, en_s2: 1'b1, four_wire_command_mode: 1'b0, cont: 1'b0, cont_quad: 1'b0, dcfg: DCFG_RST};
	localparam frame_s F_RST = '{fresh: 1'b1, phase: PH_IDLE, op: 8'h00, cnt: 5'h00,
		sh: 32'h0000_0000, addr: 24'h00_0000};
	localparam drive_s D_RST = '{sh: 8'h00, bits: 4'h0, oe: 4'h0, left: 4'h0,
		next_addr: 24'h00_0000, started: 1'b0};

	persist_s p_reg;
	persist_s p_next;
	frame_s   f_reg;
	frame_s   f_next;
	drive_s   d_reg;
	drive_s   d_next;
	core_s    c_reg;
	core_s    c_next;

	phase_e      cur_phase;
	logic [7:0]  cur_op;
	logic [4:0]  cur_cnt;
	logic [2:0]  lanes;
	logic [31:0] sh_in;
	logic [4:0]  dum;
	logic [2:0]  dw;
	logic [7:0]  byte_out;
	logic [3:0]  left_base;

	// rising edge: command, address, mode and dummy reception
	always_comb begin
		p_next         = p_reg;
		f_next         = f_reg;
		p_next.qe_s1   = i_quad_enable;
		p_next.qe_s2   = p_reg.qe_s1;
		p_next.busy_s1 = i_busy;
		p_next.busy_s2 = p_reg.busy_s1;
		p_next.en_s1   = i_clk_en;
		p_next.en_s2   = p_reg.en_s1;
		// a frame that follows an armed mode byte starts straight at the address
		if (f_reg.fresh) begin
			cur_phase = p_reg.cont ? PH_ADDR : PH_CMD;
			cur_op    = p_reg.cont_quad ? OP_QUAD_IO : OP_DUAL_IO;
		end else begin
			cur_phase = f_reg.phase;
			cur_op    = f_reg.op;
		end
		unique case (cur_phase)
			PH_CMD:          lanes = cmd_lanes(p_reg.four_wire_command_mode);
			PH_ADDR, PH_MODE: lanes = addr_lanes(cur_op, p_reg.four_wire_command_mode);
			default:         lanes = 3'h1;
		endcase
		if (f_reg.fresh) begin
			cur_cnt = p_reg.cont ? clocks_for(ADDR_LEN, lanes) : clocks_for(BYTE_LEN, lanes);
		end else begin
			cur_cnt = f_reg.cnt;
		end
		unique case (lanes)
			3'h4:    sh_in = {f_reg.sh[27:0], link.io[3:0]};
			3'h2:    sh_in = {f_reg.sh[29:0], link.io[1:0]};
			default: sh_in = {f_reg.sh[30:0], link.io[0]};
		endcase
		dum = dummy_clocks(cur_op, p_reg.four_wire_command_mode, p_reg.dcfg);
		if (p_reg.en_s2) begin
			f_next.fresh = 1'b0;
			f_next.phase = cur_phase;
			f_next.op    = cur_op;
			f_next.sh    = sh_in;
			f_next.cnt   = 5'(cur_cnt - 5'h01);
			if (cur_cnt == 5'h01) begin
				unique case (cur_phase)
					PH_CMD: begin
						f_next.op    = sh_in[7:0];
						f_next.phase = PH_IDLE;
						if (p_reg.four_wire_command_mode) begin
							if ((sh_in[7:0] == OP_FAST || sh_in[7:0] == OP_QUAD_IO)
								&& !p_reg.busy_s2) begin
								f_next.phase = PH_ADDR;
							end else if (sh_in[7:0] == OP_SET_PARAM) begin
								f_next.phase = PH_MODE;
							end else if (sh_in[7:0] == OP_EXIT) begin
								// only the mode flags move; write latch, suspend
								// and wrap length live outside this block
								p_next.four_wire_command_mode  = 1'b0;
								p_next.cont = 1'b0;
							end
						end else begin
							unique case (sh_in[7:0])
								OP_READ, OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT, OP_DUAL_IO: begin
									if (!p_reg.busy_s2) f_next.phase = PH_ADDR;
								end
								OP_QUAD_IO: begin
									if (!p_reg.busy_s2 && p_reg.qe_s2) begin
										f_next.phase = PH_ADDR;
									end
								end
								OP_ENTER_QPI: p_next.four_wire_command_mode = p_reg.qe_s2;
								OP_EXIT:      p_next.cont = 1'b0;
								default:      f_next.phase = PH_IDLE;
							endcase
						end
						if (f_next.phase == PH_ADDR) begin
							f_next.cnt = clocks_for(ADDR_LEN, addr_lanes(sh_in[7:0], p_reg.four_wire_command_mode));
						end else if (f_next.phase == PH_MODE) begin
							f_next.cnt = clocks_for(BYTE_LEN, cmd_lanes(p_reg.four_wire_command_mode));
						end
					end
					PH_ADDR: begin
						f_next.addr = sh_in[23:0];
						if (has_mode(cur_op)) begin
							f_next.phase = PH_MODE;
							f_next.cnt   = clocks_for(BYTE_LEN, lanes);
						end else if (dum != 5'h00) begin
							f_next.phase = PH_DUMMY;
							f_next.cnt   = dum;
						end else begin
							f_next.phase = PH_DATA;
						end
					end
					PH_MODE: begin
						if (cur_op == OP_SET_PARAM) begin
							p_next.dcfg  = sh_in[PARAM_LSB +: 2];
							f_next.phase = PH_IDLE;
						end else begin
							p_next.cont      = sh_in[5:4] == CONT_MATCH;
							p_next.cont_quad = cur_op == OP_QUAD_IO;
							if (dum != 5'h00) begin
								f_next.phase = PH_DUMMY;
								f_next.cnt   = dum;
							end else begin
								f_next.phase = PH_DATA;
							end
						end
					end
					PH_DUMMY: f_next.phase = PH_DATA;
					PH_DATA:  f_next.phase = PH_DATA;
					PH_IDLE:  f_next.phase = PH_IDLE;
					default:  f_next.phase = PH_IDLE;
				endcase
			end
		end
	end

	// falling edge: data lanes, one byte per 8/lanes clocks
	always_comb begin
		d_next    = d_reg;
		dw        = data_lanes(f_reg.op, p_reg.four_wire_command_mode);
		byte_out  = (d_reg.left == 4'h0) ? i_rd_data : d_reg.sh;
		left_base = (d_reg.left == 4'h0) ? 4'h8 : d_reg.left;
		if (p_reg.en_s2 && f_reg.phase == PH_DATA) begin
			if (d_reg.left == 4'h0) begin
				d_next.next_addr = 24'(o_rd_addr + 24'h00_0001);
				d_next.started   = 1'b1;
			end
			d_next.left = 4'(left_base - {1'b0, dw});
			unique case (dw)
				3'h4: begin
					d_next.bits = byte_out[7:4];
					d_next.oe   = 4'hf;
					d_next.sh   = {byte_out[3:0], 4'h0};
				end
				3'h2: begin
					d_next.bits = {2'h0, byte_out[7:6]};
					d_next.oe   = 4'h3;
					d_next.sh   = {byte_out[5:0], 2'h0};
				end
				default: begin
					d_next.bits = {2'h0, byte_out[7], 1'b0};
					d_next.oe   = 4'h2;
					d_next.sh   = {byte_out[6:0], 1'b0};
				end
			endcase
		end
	end

	assign o_rd_addr = d_reg.started ? d_reg.next_addr : f_reg.addr;

	always_ff @(posedge link.sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			p_reg <= P_RST;
		end else begin
			p_reg <= p_next;
		end
	end

	// chip select high clears the frame at once: the link clock stops with it
	always_ff @(posedge link.sclk or negedge i_rst_n or posedge link.cs_n) begin
		if (!i_rst_n) begin
			f_reg <= F_RST;
		end else if (link.cs_n) begin
			f_reg <= F_RST;
		end else begin
			f_reg <= f_next;
		end
	end

	always_ff @(negedge link.sclk or negedge i_rst_n or posedge link.cs_n) begin
		if (!i_rst_n) begin
			d_reg <= D_RST;
		end else if (link.cs_n) begin
			d_reg <= D_RST;
		end else begin
			d_reg <= d_next;
		end
	end

	assign link.dev_o  = d_reg.bits;
	assign link.dev_oe = d_reg.oe;

	// mode flags cross to the core clock as plain levels
	always_comb begin
		c_next = c_reg;
		if (i_clk_en) begin
			c_next.qpi_s1  = p_reg.four_wire_command_mode;
			c_next.qpi_s2  = c_reg.qpi_s1;
			c_next.cont_s1 = p_reg.cont;
			c_next.cont_s2 = c_reg.cont_s1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			c_reg <= '0;
		end else begin
			c_reg <= c_next;
		end
	end

	assign o_four_wire_mode   = c_reg.qpi_s2;
	assign o_continuous_armed = c_reg.cont_s2;

endmodule : spi_flash_read_device

// [core/spi_flash_read_host.sv]
// host end: issues one flash command per request, link clock = core clock / 4
// assumes the device answers on falling sclk; lanes are resynchronised here
`timescale 1ns/1ps
module spi_flash_read_host (
	spi_flash_link_if.host_mp                 link,
	input  wire logic                         i_core_clk,
	input  wire logic                         i_rst_n,
	input  wire logic                         i_clk_en,
	input  wire logic                         i_req,
	input  wire logic [7:0]                   i_opcode,
	input  wire logic [spi_flash_pkg::ADDR_BITS-1:0] i_addr,
	input  wire logic [7:0]                   i_mode_byte,
	input  wire logic                         i_skip_opcode,
	input  wire logic                         i_qpi,
	input  wire logic [1:0]                   i_dummy_sel,
	input  wire logic [15:0]                  i_len,
	output logic                              o_busy,
	output logic                              o_rd_valid,
	output logic [7:0]                        o_rd_data
);
	import spi_flash_pkg::*;

	typedef struct packed {
		phase_e      ph;
		logic [1:0]  div;
		logic        sclk;
		logic        cs_n;
		logic [7:0]  op;
		logic        four_wire_command_mode;
		logic [1:0]  dsel;
		logic [23:0] addr;
		logic [7:0]  mode;
		logic [4:0]  left;
		logic [31:0] tx;
		logic [3:0]  out;
		logic [3:0]  oe;
		logic [7:0]  rx;
		logic [3:0]  rx_bits;
		logic [15:0] len;
		logic        rd_valid;
		logic [7:0]  rd_data;
		logic [3:0]  io_s1;
		logic [3:0]  io_s2;
	} host_s;

	host_s      h_reg;
	host_s      h_next;
	logic       present;
	logic       finish;
	logic       body;
	logic [2:0] w;
	logic [4:0] dum;

	always_comb begin
		h_next          = h_reg;
		present         = 1'b0;
		finish          = 1'b0;
		body            = 1'b0;
		h_next.rd_valid = 1'b0;
		w               = data_lanes(h_reg.op, h_reg.four_wire_command_mode);
		dum             = dummy_clocks(h_reg.op, h_reg.four_wire_command_mode, h_reg.dsel);
		if (i_clk_en) begin
			h_next.io_s1 = link.io;
			h_next.io_s2 = h_reg.io_s1;
			if (h_reg.ph == PH_IDLE) begin
				if (i_req) begin
					h_next.op      = i_opcode;
					h_next.four_wire_command_mode     = i_qpi;
					h_next.dsel    = i_dummy_sel;
					h_next.addr    = i_addr;
					h_next.mode    = i_mode_byte;
					h_next.len     = i_len;
					h_next.cs_n    = 1'b0;
					h_next.div     = 2'h0;
					h_next.rx_bits = 4'h0;
					present        = 1'b1;
					if (i_skip_opcode) begin
						h_next.ph   = PH_ADDR;
						h_next.tx   = {i_addr, 8'h00};
						h_next.left = clocks_for(ADDR_LEN, addr_lanes(i_opcode, i_qpi));
					end else begin
						h_next.ph   = PH_CMD;
						h_next.tx   = {i_opcode, 24'h00_0000};
						h_next.left = clocks_for(BYTE_LEN, cmd_lanes(i_qpi));
					end
				end
			end else begin
				h_next.div  = 2'(h_reg.div + 2'h1);
				h_next.sclk = h_next.div[1];
				// tick: falling edge made here, inputs sampled, next bits presented
				if (h_reg.div == 2'h3) begin
					h_next.left = 5'(h_reg.left - 5'h01);
					unique case (h_reg.ph)
						PH_CMD: begin
							if (h_reg.left != 5'h01) begin
								present = 1'b1;
							end else if (h_reg.op == OP_EXIT || h_reg.op == OP_ENTER_QPI) begin
								finish = 1'b1;
							end else if (h_reg.op == OP_SET_PARAM) begin
								h_next.ph   = PH_MODE;
								h_next.tx   = {h_reg.mode, 24'h00_0000};
								h_next.left = clocks_for(BYTE_LEN, cmd_lanes(h_reg.four_wire_command_mode));
								present     = 1'b1;
							end else begin
								h_next.ph   = PH_ADDR;
								h_next.tx   = {h_reg.addr, 8'h00};
								h_next.left = clocks_for(ADDR_LEN, addr_lanes(h_reg.op, h_reg.four_wire_command_mode));
								present     = 1'b1;
							end
						end
						PH_ADDR: begin
							if (h_reg.left != 5'h01) begin
								present = 1'b1;
							end else if (has_mode(h_reg.op)) begin
								h_next.ph   = PH_MODE;
								h_next.tx   = {h_reg.mode, 24'h00_0000};
								h_next.left = clocks_for(BYTE_LEN, addr_lanes(h_reg.op, h_reg.four_wire_command_mode));
								present     = 1'b1;
							end else begin
								body = 1'b1;
							end
						end
						PH_MODE: begin
							if (h_reg.left != 5'h01) begin
								present = 1'b1;
							end else if (h_reg.op == OP_SET_PARAM) begin
								finish = 1'b1;
							end else begin
								body = 1'b1;
							end
						end
						PH_DUMMY: begin
							if (h_reg.left == 5'h01) h_next.ph = PH_DATA;
						end
						PH_DATA: begin
							unique case (w)
								3'h4:    h_next.rx = {h_reg.rx[3:0], h_reg.io_s2};
								3'h2:    h_next.rx = {h_reg.rx[5:0], h_reg.io_s2[1:0]};
								default: h_next.rx = {h_reg.rx[6:0], h_reg.io_s2[1]};
							endcase
							h_next.rx_bits = 4'(h_reg.rx_bits + {1'b0, w});
							if (h_next.rx_bits == 4'h8) begin
								h_next.rx_bits  = 4'h0;
								h_next.rd_valid = 1'b1;
								h_next.rd_data  = h_next.rx;
								h_next.len      = 16'(h_reg.len - 16'h0001);
								finish          = h_reg.len <= 16'h0001;
							end
						end
						default: finish = 1'b1;
					endcase
				end
			end
			// turn-around: host lets go of every lane before dummies and data
			if (body) begin
				h_next.oe = 4'h0;
				if (dum != 5'h00) begin
					h_next.ph   = PH_DUMMY;
					h_next.left = dum;
				end else begin
					h_next.ph = PH_DATA;
				end
			end
			if (present) begin
				unique case (h_next.ph)
					PH_CMD:  w = cmd_lanes(h_next.four_wire_command_mode);
					default: w = addr_lanes(h_next.op, h_next.four_wire_command_mode);
				endcase
				h_next.oe = lane_mask(w);
				unique case (w)
					3'h4:    h_next.out = h_next.tx[31:28];
					3'h2:    h_next.out = {2'h0, h_next.tx[31:30]};
					default: h_next.out = {3'h0, h_next.tx[31]};
				endcase
				h_next.tx = h_next.tx << w;
			end
			if (finish) begin
				h_next.ph   = PH_IDLE;
				h_next.cs_n = 1'b1;
				h_next.sclk = 1'b0;
				h_next.oe   = 4'h0;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			h_reg      <= '0;
			h_reg.ph   <= PH_IDLE;
			h_reg.cs_n <= 1'b1;
		end else begin
			h_reg <= h_next;
		end
	end

	assign link.sclk    = h_reg.sclk;
	assign link.cs_n    = h_reg.cs_n;
	assign link.host_o  = h_reg.out;
	assign link.host_oe = h_reg.oe;
	assign o_busy       = h_reg.ph != PH_IDLE;
	assign o_rd_valid   = h_reg.rd_valid;
	assign o_rd_data    = h_reg.rd_data;

endmodule : spi_flash_read_host

// [test/spi_flash_read_chk.sv]
// link checker: timing and lane ownership on the shared flash link
// assumes sclk is a core-clock divider made by the host end
`timescale 1ns/1ps
module spi_flash_read_chk (
	input wire logic       i_core_clk,
	input wire logic       i_rst_n,
	input wire logic       i_sclk,
	input wire logic       i_cs_n,
	input wire logic [3:0] i_host_o,
	input wire logic [3:0] i_host_oe,
	input wire logic [3:0] i_dev_o,
	input wire logic [3:0] i_dev_oe
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	property p_release;
		i_cs_n |-> i_dev_oe == 4'h0;
	endproperty
	a_release: assert property (p_release) else $error("device drives while deselected");
	property p_dev_fall;
		!i_cs_n && $changed(i_dev_o & i_dev_oe) |-> $fell(i_sclk);
	endproperty
	a_dev_fall: assert property (p_dev_fall) else $error("device lane moved off falling edge");
	property p_host_low;
		!i_cs_n && $changed(i_host_o & i_host_oe) |-> !i_sclk;
	endproperty
	a_host_low: assert property (p_host_low) else $error("host lane moved while sclk high");
	// both ends driving a lane at once would hide any data fault
	property p_no_fight;
		(i_host_oe & i_dev_oe) == 4'h0;
	endproperty
	a_no_fight: assert property (p_no_fight) else $error("lane driven by both ends");
	property p_idle;
		i_cs_n |-> !i_sclk;
	endproperty
	a_idle: assert property (p_idle) else $error("sclk moving outside a frame");
	property p_sclk_shape;
		$rose(i_sclk) |=> i_sclk ##1 !i_sclk [*2];
	endproperty
	a_sclk_shape: assert property (p_sclk_shape) else $error("sclk not a divide by four");
	property p_quiet_start;
		$fell(i_cs_n) |-> (i_dev_oe == 4'h0) [*8];
	endproperty
	a_quiet_start: assert property (p_quiet_start) else $error("device drove too early");
	property p_lanes;
		!i_cs_n |-> i_dev_oe inside {4'h0, 4'h2, 4'h3, 4'hf};
	endproperty
	a_lanes: assert property (p_lanes) else $error("device lane set illegal");
	c_quad: cover property (!i_cs_n && i_dev_oe == 4'hf);
	c_dual: cover property (!i_cs_n && i_dev_oe == 4'h3);
	c_single: cover property (!i_cs_n && i_dev_oe == 4'h2);
endmodule : spi_flash_read_chk

// [test/tb_top.sv]
// bench: host end and device end joined by the link, rows of reads
// assumes a combinational memory image behind the device address
`timescale 1ns/1ps
module tb_top;
	import spi_flash_pkg::*;
	typedef struct packed {
		logic [7:0]  op;
		logic [23:0] a;
		logic [7:0]  m;
		logic        sk;
		logic        q;
		logic [1:0]  ds;
		logic [7:0]  n;
		logic        ff;
		logic        fw;
		logic        arm;
	} row_s;
	logic        clk = 1'b0;
	logic        rst_n = 1'b1;
	logic        qe = 1'b1;
	logic        busy = 1'b0;
	logic        req = 1'b0;
	logic        skip = 1'b0;
	logic        four_wire_command_mode = 1'b0;
	logic        h_busy, rd_valid, fw, arm;
	logic [7:0]  op = 8'h00, mode = 8'h00, rd_data, mem;
	logic [1:0]  dsel = 2'h0;
	logic [15:0] len = 16'h0000;
	logic [23:0] addr = 24'h000000, rd_addr;
	int          errors = 0, checks_done = 0;
	row_s        rows [16] = '{
		'{8'h03, 24'h000010, 8'h00, 0, 0, 0, 3, 0, 0, 0},
		'{8'h0b, 24'h0000fe, 8'h00, 0, 0, 0, 3, 0, 0, 0},
		'{8'h3b, 24'h123456, 8'h00, 0, 0, 0, 2, 0, 0, 0},
		'{8'h6b, 24'habcdef, 8'h00, 0, 0, 0, 2, 0, 0, 0},
		'{8'hbb, 24'h00a000, 8'h20, 0, 0, 0, 2, 0, 0, 1},
		'{8'hbb, 24'h00b000, 8'h00, 1, 0, 0, 1, 0, 0, 0},
		'{8'heb, 24'h00c000, 8'h20, 0, 0, 0, 2, 0, 0, 1},
		'{8'heb, 24'h00d000, 8'h20, 1, 0, 0, 1, 0, 0, 1},
		'{8'hff, 24'h000000, 8'h00, 0, 0, 0, 0, 0, 0, 0},
		'{8'h38, 24'h000000, 8'h00, 0, 0, 0, 0, 0, 1, 0},
		'{8'h0b, 24'h00e001, 8'h00, 0, 1, 0, 2, 0, 1, 0},
		'{8'hc0, 24'h000000, 8'h20, 0, 1, 0, 0, 0, 1, 0},
		'{8'h0b, 24'h00e101, 8'h00, 0, 1, 2, 2, 0, 1, 0},
		'{8'heb, 24'h00e201, 8'h00, 0, 1, 2, 2, 0, 1, 0},
		'{8'h03, 24'h00e301, 8'h00, 0, 1, 0, 1, 1, 1, 0},
		'{8'hff, 24'h000000, 8'h00, 0, 1, 0, 0, 0, 0, 0}};

	spi_flash_link_if link ();
	spi_flash_read_host i_spi_flash_read_host (.link(link), .i_core_clk(clk), .i_rst_n(rst_n),
		.i_clk_en(1'b1), .i_req(req), .i_opcode(op), .i_addr(addr), .i_mode_byte(mode),
		.i_skip_opcode(skip), .i_qpi(four_wire_command_mode), .i_dummy_sel(dsel), .i_len(len), .o_busy(h_busy),
		.o_rd_valid(rd_valid), .o_rd_data(rd_data));
	spi_flash_read_device i_spi_flash_read_device (.link(link), .i_core_clk(clk),
		.i_rst_n(rst_n), .i_clk_en(1'b1), .i_quad_enable(qe), .i_busy(busy),
		.i_rd_data(mem), .o_rd_addr(rd_addr), .o_four_wire_mode(fw), .o_continuous_armed(arm));
	spi_flash_read_chk i_spi_flash_read_chk (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_sclk(link.sclk), .i_cs_n(link.cs_n), .i_host_o(link.host_o),
		.i_host_oe(link.host_oe), .i_dev_o(link.dev_o), .i_dev_oe(link.dev_oe));

	always #5 clk = ~clk;

	function automatic logic [7:0] img(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction : img
	assign mem = img(rd_addr);

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk8

	task automatic chk1(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask : chk1

	task automatic run(input row_s r);
		int k;
		k = 0;
		@(posedge clk);
		req <= 1'b1;
		op <= r.op;
		addr <= r.a;
		mode <= r.m;
		skip <= r.sk;
		four_wire_command_mode <= r.q;
		dsel <= r.ds;
		len <= 16'(r.n);
		@(posedge clk);
		req <= 1'b0;
		for (int t = 0; t < 4000; t++) begin
			@(posedge clk);
			#1;
			if (rd_valid === 1'b1) begin
				chk8("data", r.ff ? 8'hff : img(r.a + 24'(k)), rd_data);
				k++;
			end
			if (h_busy === 1'b0) break;
		end
		chk8("count", r.n, 8'(k));
		// mode flags cross two flops into the core domain
		repeat (4) @(posedge clk);
		#1;
		chk1("four_wire", r.fw, fw);
		chk1("armed", r.arm, arm);
		$display("test op %h addr %h done", r.op, r.a);
	endtask : run

	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		// a real falling edge, so link-clocked state resets with no sclk running
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) run(rows[i]);
		@(posedge clk);
		busy <= 1'b1;
		run('{8'h0b, 24'h000200, 8'h00, 0, 0, 0, 1, 1, 0, 0});
		@(posedge clk);
		busy <= 1'b0;
		qe <= 1'b0;
		run('{8'h38, 24'h000000, 8'h00, 0, 0, 0, 0, 0, 0, 0});
		run('{8'heb, 24'h000300, 8'h00, 0, 0, 0, 1, 1, 0, 0});
		run('{8'hbb, 24'h000400, 8'h20, 0, 0, 0, 1, 0, 0, 1});
		@(posedge clk);
		rst_n <= 1'b0;
		qe <= 1'b1;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk1("armed_rst", 1'b0, arm);
		chk1("four_wire_rst", 1'b0, fw);
		$display("test reset done");
		// dummy field must be back at four clocks after reset
		run('{8'h38, 24'h000000, 8'h00, 0, 0, 0, 0, 0, 1, 0});
		run('{8'h0b, 24'h00f001, 8'h00, 0, 1, 0, 2, 0, 1, 0});
		run('{8'hc0, 24'h000000, 8'h10, 0, 1, 0, 0, 0, 1, 0});
		run('{8'h0b, 24'h00f101, 8'h00, 0, 1, 1, 1, 0, 1, 0});
		run('{8'hc0, 24'h000000, 8'h30, 0, 1, 0, 0, 0, 1, 0});
		run('{8'heb, 24'h00f201, 8'h00, 0, 1, 3, 2, 0, 1, 0});
		run('{8'hff, 24'h000000, 8'h00, 0, 1, 0, 0, 0, 0, 0});
		end_sim;
	end

	// 27 frames of at most a few hundred cycles each
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		end_sim;
	end
endmodule : tb_top
